// [bfs_consts.svh]
// constants for the breaker failure supervision block
`ifndef BFS_CONSTS_SVH
`define BFS_CONSTS_SVH
`define BFS_CLK_HZ          50000000
`define BFS_SUP_TIME_MS     150
`define BFS_SUP_CYCLES      ((`BFS_SUP_TIME_MS * (`BFS_CLK_HZ / 1000)))
`define BFS_CUR_W           16
`define BFS_THRESH_RST      16'h0100
`define BFS_NUM_EXTRA       3
`endif

// [bfs_pkg.sv]
// types for the breaker failure supervision block
package bfs_pkg;
  typedef enum logic [1:0] {
    BFS_CURRENT,
    BFS_POSITION,
    BFS_COMBINED
  } bfs_scheme_t;
  typedef enum logic [1:0] {
    BFS_TRIG_ALL,
    BFS_TRIG_EXTERNAL,
    BFS_TRIG_OVERCURRENT,
    BFS_TRIG_NONE
  } bfs_trig_mode_t;
  typedef enum logic [1:0] {
    BFS_STANDBY,
    BFS_TIMING,
    BFS_REJECTED,
    BFS_TRIPPED
  } bfs_state_t;
endpackage

// [bfs_breaker_failure_supervision.sv]
// breaker failure supervision: trigger select, supervision timer, backup trip and lock
// Overview of operation
// - scheme selects current check, position check, or both combined
// - current scheme: failure when current stays at or above threshold to expiry
// - position scheme: failure when position never reports open before expiry
// - combined scheme: failure only if current high and position not open
// - trigger starts timer; timer keeps running after trigger drops
// - timer expiry without detected opening asserts backup trip output
// - detected opening per active scheme stops the timer
// - opening seen with triggers active enters rejected, stays while triggered
// - rejected returns to stand-by once all triggers drop
// - lock output set with trip, held after trip and triggers drop
// - lock clears only on operator acknowledgement
// - trigger source mode: all, external, overcurrent trips, or none
// - three extra trigger inputs also start supervision
`include "bfs_consts.svh"
module bfs_breaker_failure_supervision #(
  parameter int unsigned CUR_W      = `BFS_CUR_W,
  parameter int unsigned NUM_EXTRA  = `BFS_NUM_EXTRA,
  parameter int unsigned SUP_CYCLES = `BFS_SUP_CYCLES,
  parameter int unsigned CNT_W      = 24
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire bfs_pkg::bfs_scheme_t    scheme,
  input  wire bfs_pkg::bfs_trig_mode_t trig_mode,
  input  wire logic [CNT_W-1:0]       failure_supervision_time,
  input  wire logic [CUR_W-1:0]       failure_current_threshold,
  input  wire logic [CUR_W-1:0]       phase_current,
  input  wire logic                   all_trip_cmd,
  input  wire logic                   external_trip_cmd,
  input  wire logic                   overcurrent_trip_cmd,
  input  wire logic [NUM_EXTRA-1:0]   extra_trigger_input,
  input  wire logic                   pos_open_pin,
  input  wire logic                   lock_ack,
  output logic                        failure_trip,
  output logic                        lock_out,
  output bfs_pkg::bfs_state_t         state_out
);

  // pins from the switchyard are asynchronous: two flops each; only the
  // second flop is ever read, so a metastable first stage cannot leak
  logic [NUM_EXTRA+3:0] pin_meta_reg;
  logic [NUM_EXTRA+3:0] pin_meta_next;
  logic [NUM_EXTRA+3:0] pin_sync_reg;
  logic [NUM_EXTRA+3:0] pin_sync_next;
  always_comb begin
    pin_meta_next = {extra_trigger_input, pos_open_pin, all_trip_cmd,
                     external_trip_cmd, overcurrent_trip_cmd};
    pin_sync_next = pin_meta_reg;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  logic [NUM_EXTRA-1:0] extra_s;
  logic                 pos_open_s;
  logic                 all_s;
  logic                 ext_s;
  logic                 oc_s;
  assign {extra_s, pos_open_s, all_s, ext_s, oc_s} = pin_sync_reg;

  // trigger source chosen by mode, ored with the extra inputs
  logic mode_trig;
  logic trig_any;
  always_comb begin
    unique case (trig_mode)
      bfs_pkg::BFS_TRIG_ALL:         mode_trig = all_s;
      bfs_pkg::BFS_TRIG_EXTERNAL:    mode_trig = ext_s;
      bfs_pkg::BFS_TRIG_OVERCURRENT: mode_trig = oc_s;
      bfs_pkg::BFS_TRIG_NONE:        mode_trig = 1'b0;
    endcase
  end
  assign trig_any = mode_trig | (|extra_s);

  // opening criteria per scheme; current compare is same-domain data
  logic cur_high;
  logic opened;
  assign cur_high = (phase_current >= failure_current_threshold);
  always_comb begin
    unique case (scheme)
      bfs_pkg::BFS_CURRENT:  opened = !cur_high;
      bfs_pkg::BFS_POSITION: opened = pos_open_s;
      bfs_pkg::BFS_COMBINED: opened = !cur_high || pos_open_s;
      default:               opened = !cur_high;
    endcase
  end

  // supervision state machine and timer
  bfs_pkg::bfs_state_t state_reg;
  bfs_pkg::bfs_state_t state_next;
  logic [CNT_W-1:0]    cnt_reg;
  logic [CNT_W-1:0]    cnt_next;
  logic                trip_reg;
  logic                trip_next;
  logic                lock_reg;
  logic                lock_next;
  logic                expire;
  // a zero supervision time is treated as one cycle
  assign expire = (cnt_reg + 1'b1 >= failure_supervision_time);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    trip_next  = trip_reg;
    lock_next  = lock_reg;
    unique case (state_reg)
      bfs_pkg::BFS_STANDBY: begin
        trip_next = 1'b0;
        cnt_next  = '0;
        if (trig_any) begin
          state_next = bfs_pkg::BFS_TIMING;
        end
      end
      bfs_pkg::BFS_TIMING: begin
        // timer ignores trigger level: no restart, no extension
        if (opened) begin
          cnt_next   = '0;
          state_next = trig_any ? bfs_pkg::BFS_REJECTED
                                : bfs_pkg::BFS_STANDBY;
        end else if (expire) begin
          trip_next  = 1'b1;
          lock_next  = 1'b1;
          state_next = bfs_pkg::BFS_TRIPPED;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      bfs_pkg::BFS_REJECTED: begin
        if (!trig_any) begin
          state_next = bfs_pkg::BFS_STANDBY;
        end
      end
      bfs_pkg::BFS_TRIPPED: begin
        // trip drops once the breaker opens and triggers fall back
        if (opened && !trig_any) begin
          trip_next  = 1'b0;
          state_next = bfs_pkg::BFS_STANDBY;
        end
      end
    endcase
    // ack loses to a fresh trip in the same cycle
    if (lock_ack && !(trip_next && !trip_reg)) begin
      lock_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= bfs_pkg::BFS_STANDBY;
      cnt_reg   <= '0;
      trip_reg  <= 1'b0;
      lock_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      trip_reg  <= trip_next;
      lock_reg  <= lock_next;
    end
  end

  assign failure_trip = trip_reg;
  assign lock_out     = lock_reg;
  assign state_out    = state_reg;

  // independent length of the timing phase, read only by the checks below;
  // kept apart from cnt_reg so a counter fault cannot hide itself
  logic [CNT_W-1:0] timing_len_reg;
  logic [CNT_W-1:0] timing_len_next;
  always_comb begin
    timing_len_next = '0;
    if (state_reg == bfs_pkg::BFS_TIMING) begin
      timing_len_next = timing_len_reg + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timing_len_reg <= '0;
    end else begin
      timing_len_reg <= timing_len_next;
    end
  end

  // checks: lock and acknowledge
  a_trip_with_lock: assert property (@(posedge clk) disable iff (!rstn)
    $rose(trip_reg) |-> lock_reg)
    else $error("lock not set with trip");
  a_lock_holds: assert property (@(posedge clk) disable iff (!rstn)
    lock_reg && !lock_ack |=> lock_reg)
    else $error("lock dropped without ack");
  a_lock_ack_clears: assert property (@(posedge clk) disable iff (!rstn)
    lock_reg && lock_ack && !$rose(trip_next) && state_reg != bfs_pkg::BFS_TIMING
      |=> !lock_reg)
    else $error("ack did not clear lock");
  a_lock_from_trip: assert property (@(posedge clk) disable iff (!rstn)
    $rose(lock_reg) |-> $rose(trip_reg))
    else $error("lock set without trip");
  a_ack_set_wins: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TIMING && !opened && expire && lock_ack |=> lock_reg)
    else $error("ack beat a fresh trip");
  a_lock_needs_ack: assert property (@(posedge clk) disable iff (!rstn)
    $fell(lock_reg) |-> $past(lock_ack))
    else $error("lock cleared without ack");

  // checks: starting and running the timer
  a_start_standby: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_STANDBY && trig_any |=> state_reg == bfs_pkg::BFS_TIMING)
    else $error("trigger did not start timer");
  a_timer_runs: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TIMING && !opened && !expire
      |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("timer not advancing");
  a_timing_entry: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TIMING && $past(state_reg) != bfs_pkg::BFS_TIMING
      |-> $past(state_reg) == bfs_pkg::BFS_STANDBY)
    else $error("timing entered from wrong state");
  a_timing_cnt_zero: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TIMING && $past(state_reg) == bfs_pkg::BFS_STANDBY
      |-> cnt_reg == '0)
    else $error("timer not started from zero");
  a_timing_bounded: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TIMING
      |-> timing_len_reg < failure_supervision_time || timing_len_reg == '0)
    else $error("timing outlasted supervision time");

  // checks: expiry and backup trip
  a_expire_trip: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TIMING && !opened && expire |=> trip_reg)
    else $error("no trip at expiry");
  a_trip_delay: assert property (@(posedge clk) disable iff (!rstn)
    $rose(trip_reg) && failure_supervision_time != '0
      |-> timing_len_reg == failure_supervision_time)
    else $error("trip not at supervision time");
  a_trip_state: assert property (@(posedge clk) disable iff (!rstn)
    trip_reg == (state_reg == bfs_pkg::BFS_TRIPPED))
    else $error("trip output out of step with state");
  a_trip_from_timing: assert property (@(posedge clk) disable iff (!rstn)
    $rose(trip_reg) |-> $past(state_reg) == bfs_pkg::BFS_TIMING)
    else $error("trip raised outside timing");
  a_trip_holds: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TRIPPED && !(opened && !trig_any) |=> trip_reg)
    else $error("trip dropped too early");
  a_trip_release: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TRIPPED && opened && !trig_any
      |=> !trip_reg && state_reg == bfs_pkg::BFS_STANDBY)
    else $error("trip not released after opening");

  // checks: opening per scheme and the rejected state
  a_open_stops: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_TIMING && opened |=> !trip_reg && cnt_reg == '0)
    else $error("opening did not stop timer");
  a_current_open: assert property (@(posedge clk) disable iff (!rstn)
    scheme == bfs_pkg::BFS_CURRENT && state_reg == bfs_pkg::BFS_TIMING && !cur_high
      |=> state_reg != bfs_pkg::BFS_TIMING && !trip_reg)
    else $error("current drop did not stop timer");
  a_position_open: assert property (@(posedge clk) disable iff (!rstn)
    scheme == bfs_pkg::BFS_POSITION && state_reg == bfs_pkg::BFS_TIMING && pos_open_s
      |=> state_reg != bfs_pkg::BFS_TIMING && !trip_reg)
    else $error("open position did not stop timer");
  a_scheme_comb: assert property (@(posedge clk) disable iff (!rstn)
    scheme == bfs_pkg::BFS_COMBINED && state_reg == bfs_pkg::BFS_TIMING && !cur_high
      |=> !trip_reg)
    else $error("combined scheme tripped with low current");
  a_comb_pos_open: assert property (@(posedge clk) disable iff (!rstn)
    scheme == bfs_pkg::BFS_COMBINED && state_reg == bfs_pkg::BFS_TIMING && pos_open_s
      |=> !trip_reg)
    else $error("combined scheme tripped with open position");
  a_reject_hold: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_REJECTED && trig_any
      |=> state_reg == bfs_pkg::BFS_REJECTED)
    else $error("left rejected while triggered");
  a_reject_entry: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_REJECTED && $past(state_reg) != bfs_pkg::BFS_REJECTED
      |-> $past(state_reg) == bfs_pkg::BFS_TIMING)
    else $error("rejected entered from wrong state");
  a_reject_no_trip: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_REJECTED |-> !trip_reg)
    else $error("trip while rejected");
  a_reject_cnt_zero: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_REJECTED |-> cnt_reg == '0)
    else $error("timer left running in rejected");
  a_reject_exit: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_REJECTED && !trig_any
      |=> state_reg == bfs_pkg::BFS_STANDBY)
    else $error("rejected did not return");

  // checks: trigger source selection
  a_trig_none: assert property (@(posedge clk) disable iff (!rstn)
    trig_mode == bfs_pkg::BFS_TRIG_NONE && extra_s == '0 |-> !trig_any)
    else $error("trigger with no source");
  a_trig_all: assert property (@(posedge clk) disable iff (!rstn)
    trig_mode == bfs_pkg::BFS_TRIG_ALL |-> trig_any == (all_s || extra_s != '0))
    else $error("all-trip mode picked wrong source");
  a_trig_ext: assert property (@(posedge clk) disable iff (!rstn)
    trig_mode == bfs_pkg::BFS_TRIG_EXTERNAL |-> trig_any == (ext_s || extra_s != '0))
    else $error("external mode picked wrong source");
  a_trig_oc: assert property (@(posedge clk) disable iff (!rstn)
    trig_mode == bfs_pkg::BFS_TRIG_OVERCURRENT |-> trig_any == (oc_s || extra_s != '0))
    else $error("overcurrent mode picked wrong source");
  a_extra_alone: assert property (@(posedge clk) disable iff (!rstn)
    extra_s != '0 |-> trig_any)
    else $error("extra input did not trigger");

  c_trip: cover property (@(posedge clk) disable iff (!rstn) $rose(trip_reg));
  c_comb_trip: cover property (@(posedge clk) disable iff (!rstn)
    scheme == bfs_pkg::BFS_COMBINED && $rose(trip_reg));
  c_reject: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_REJECTED);
  c_ack: cover property (@(posedge clk) disable iff (!rstn) $fell(lock_reg));
  c_extra: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == bfs_pkg::BFS_STANDBY && |extra_s);

endmodule

// [bfs_breaker_model.sv]
// behavioural breaker: position contact and phase current seen by the block
module bfs_breaker_model #(
  parameter int          OPEN_DELAY = 4,
  parameter logic [15:0] LOAD       = 16'h0400
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        trip_req,
  input  wire logic        close_req,
  input  wire logic        stuck_current,
  input  wire logic        stuck_position,
  output logic             pos_open,
  output logic [15:0]      phase_current
);
  logic armed;
  logic opened;
  int   cnt;
  // a trip command latches; the pole opens after a fixed mechanical delay
  always_ff @(posedge clk) begin
    if (!rstn || close_req) begin
      armed  <= 1'b0;
      opened <= 1'b0;
      cnt    <= 0;
    end else begin
      if (trip_req) armed <= 1'b1;
      if ((armed || trip_req) && !opened) cnt <= cnt + 1;
      if (cnt == OPEN_DELAY) opened <= 1'b1;
    end
  end
  // stuck flags model a failed pole or a lying contact
  assign pos_open      = opened & ~stuck_position;
  assign phase_current = (opened && !stuck_current) ? 16'h0000 : LOAD;
endmodule

// [bfs_breaker_failure_supervision_bench.sv]
// self-checking bench for the breaker failure supervision block
module bfs_breaker_failure_supervision_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10;
  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  bfs_pkg::bfs_scheme_t    scheme = bfs_pkg::BFS_CURRENT;
  bfs_pkg::bfs_trig_mode_t trig_mode = bfs_pkg::BFS_TRIG_ALL;
  logic [5:0]              trig = 6'h00;  // all, external, overcurrent, extra 0..2
  logic                    lock_ack = 1'b0;
  logic                    close_req = 1'b0;
  logic                    stuck_current = 1'b0;
  logic                    stuck_position = 1'b0;
  logic [15:0]             phase_current;
  logic                    pos_open;
  logic                    failure_trip;
  logic                    lock_out;
  bfs_pkg::bfs_state_t     state_out;
  int                      n_mismatch = 0;
  int                      cmp_count = 0;
  int                      cycles = 0;
  int                      lat;
  logic                    exp_trip;
  int                      t_mode[9] = '{0, 1, 1, 2, 2, 3, 3, 3, 3};
  int                      t_src[9] = '{0, 1, 2, 2, 1, 0, 3, 4, 5};
  logic                    t_go[9] = '{1, 1, 0, 1, 0, 0, 1, 1, 1};
  always #10 clk = ~clk;
  bfs_breaker_failure_supervision bfs_breaker_failure_supervision_inst (
    .clk(clk), .rstn(rstn), .scheme(scheme), .trig_mode(trig_mode),
    .failure_supervision_time(24'h00000a), .failure_current_threshold(16'h0100),
    .phase_current(phase_current), .all_trip_cmd(trig[0]), .external_trip_cmd(trig[1]),
    .overcurrent_trip_cmd(trig[2]), .extra_trigger_input(trig[5:3]), .pos_open_pin(pos_open),
    .lock_ack(lock_ack), .failure_trip(failure_trip), .lock_out(lock_out),
    .state_out(state_out));
  bfs_breaker_model bfs_breaker_model_inst (
    .clk(clk), .rstn(rstn), .trip_req(|trig), .close_req(close_req),
    .stuck_current(stuck_current), .stuck_position(stuck_position),
    .pos_open(pos_open), .phase_current(phase_current));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_val(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_state(bfs_pkg::bfs_state_t got, bfs_pkg::bfs_state_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reclose the breaker and let the synchronisers settle before the next case
  task automatic reclose();
    stuck_current = 1'b0;
    stuck_position = 1'b0;
    close_req = 1'b1;
    step(1);
    close_req = 1'b0;
    step(4);
  endtask
  initial begin
    step(6);
    rstn = 1'b1;
    step(1);
    check_state(state_out, bfs_pkg::BFS_STANDBY);
    check_val({31'h0, lock_out | failure_trip}, 32'h0);
    // every scheme against every kind of stuck breaker; trigger is only a short pulse
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 3; k++) begin
        scheme = bfs_pkg::bfs_scheme_t'(s);
        stuck_current = (k != 1);
        stuck_position = (k != 0);
        exp_trip = (s == 0) ? stuck_current : (s == 1) ? stuck_position
                 : (stuck_current & stuck_position);
        trig[0] = 1'b1;
        lat = 0;
        for (int i = 1; i <= T + 8; i++) begin
          step(1);
          if (i == 2) trig[0] = 1'b0;
          if (lat == 0 && failure_trip === 1'b1) lat = i;
        end
        check_val(lat, exp_trip ? T + 3 : 0);
        check_val({31'h0, lock_out}, {31'h0, exp_trip});
        if (exp_trip) begin
          stuck_current = 1'b0;
          stuck_position = 1'b0;
          step(5);
          check_val({31'h0, failure_trip}, 32'h0);
          check_val({31'h0, lock_out}, 32'h1);
          lock_ack = 1'b1;
          step(1);
          check_val({31'h0, lock_out}, 32'h0);
          lock_ack = 1'b0;
        end
        check_state(state_out, bfs_pkg::BFS_STANDBY);
        reclose();
      end
    end
    $display("scheme test done");
    // trigger source selection, held trigger gives rejected state
    scheme = bfs_pkg::BFS_POSITION;
    for (int j = 0; j < 9; j++) begin
      trig_mode = bfs_pkg::bfs_trig_mode_t'(t_mode[j]);
      trig[t_src[j]] = 1'b1;
      step(3);
      check_state(state_out, t_go[j] ? bfs_pkg::BFS_TIMING : bfs_pkg::BFS_STANDBY);
      step(2 * T);
      check_state(state_out, t_go[j] ? bfs_pkg::BFS_REJECTED : bfs_pkg::BFS_STANDBY);
      check_val({31'h0, failure_trip}, 32'h0);
      trig = 6'h00;
      step(4);
      check_state(state_out, bfs_pkg::BFS_STANDBY);
      reclose();
    end
    $display("trigger test done");
    finish_test();
  end
endmodule
